// ---- hdl/pboa_map.vh ----
// constants for the processor bus ownership arbiter
`ifndef PBOA_MAP_VH
`define PBOA_MAP_VH
`define PBOA_CLK_NS        5
`define PBOA_TMO_US        15
`define PBOA_TMO_CYC       ((`PBOA_TMO_US * 1000) / `PBOA_CLK_NS)
`define PBOA_TMO_W         12
`define PBOA_CMP_DLY_NS    50
`define PBOA_CMP_DLY_CYC   ((`PBOA_CMP_DLY_NS + `PBOA_CLK_NS - 1) / `PBOA_CLK_NS)
`define PBOA_DLY_W         4
`define PBOA_LVL_W         4
`define PBOA_PRI_W         3
`define PBOA_PRI_BASE      3'h4
`define PBOA_DATA_W        16
`define PBOA_ST_IDLE       4'h1
`define PBOA_ST_GRANT      4'h2
`define PBOA_ST_WAIT_ACK   4'h4
`define PBOA_ST_LENT       4'h8
`endif

// ---- hdl/pboa_sync.v ----
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pboa_sync #(
  parameter W = 1
) (
  input  wire         clock,   // system clock
  input  wire         arst_n,  // async reset
  input  wire [W-1:0] d,       // raw pins
  output reg  [W-1:0] q        // synchronised
);
  reg [W-1:0] meta_r;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // pboa_sync
`default_nettype wire

// ---- hdl/pboa_timeout.v ----
// enableable bus timeout counter with sticky expiry flag
`timescale 1ns/10ps
`default_nettype none
`include "pboa_map.vh"
module pboa_timeout #(
  parameter TMO_CYC = `PBOA_TMO_CYC
) (
  input  wire clock,     // system clock
  input  wire arst_n,    // async reset
  input  wire run,       // waiting for answer
  input  wire disable_t, // maintenance disable
  input  wire clear,     // clear expiry flag
  output reg  expired    // sticky expiry
);
  // cut to the counter width on purpose; the count must fit in it
  localparam integer LAST_I = TMO_CYC - 1;
  localparam [`PBOA_TMO_W-1:0] LAST = LAST_I[`PBOA_TMO_W-1:0];
  reg [`PBOA_TMO_W-1:0] cnt_r;
  wire hit = run && !disable_t && (cnt_r == LAST);
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r   <= {`PBOA_TMO_W{1'b0}};
      expired <= 1'b0;
    end else begin
      if (!run || disable_t)
        cnt_r <= {`PBOA_TMO_W{1'b0}};
      else if (!hit)
        cnt_r <= cnt_r + 1'b1;
      // set wins over clear
      if (hit)
        expired <= 1'b1;
      else if (clear)
        expired <= 1'b0;
    end
  end
endmodule // pboa_timeout
`default_nettype wire

// ---- hdl/pboa_arbiter.v ----
// processor bus ownership arbiter: requests, grants, register answer, timeouts
`timescale 1ns/10ps
`default_nettype none
`include "pboa_map.vh"
module pboa_arbiter #(
  parameter TMO_CYC = `PBOA_TMO_CYC
) (
  input  wire                      clock,             // system clock
  input  wire                      arst_n,            // async reset
  // processor-side events (same domain)
  input  wire                      bus_cycle_begin,   // processor wants a data cycle
  input  wire                      cycle_end,         // processor cycle terminated
  input  wire                      clock_restart,     // clock logic restarted
  input  wire                      service_branch_test, // branch test in service flow
  input  wire                      instruction_load_clock, // ir load, overlap fetch
  input  wire                      cycle_is_datip,    // current cycle is read-pause
  input  wire                      cycle_is_dato,     // current cycle is write
  input  wire                      console_op,        // console operation active
  input  wire                      remote_begin,      // remote load-address start
  input  wire                      stack_limit_fitted, // stack-limit option present
  input  wire [`PBOA_PRI_W-1:0]    status_priority,   // status word priority
  input  wire                      end_of_instruction, // service point reached
  input  wire                      no_ack_timeout_flag_disable,    // maintenance disable
  input  wire                      no_data_timeout_flag_disable,     // maintenance disable
  input  wire                      no_data_timeout_flag_ack,         // trap taken, clear flag
  // bus pins
  input  wire                      bus_msyn,          // bus master sync
  input  wire                      bus_ssyn_in,       // peripheral slave sync
  input  wire                      bus_sack,          // selection ack
  input  wire                      bus_npr,           // non-processor request
  input  wire [`PBOA_LVL_W-1:0]    bus_br,            // requests levels 7..4
  input  wire                      console_halt,      // halt switch
  input  wire                      ac_low,            // ac power low
  input  wire                      external_request_clock, // option clock
  input  wire                      status_reg_select, // address decode
  input  wire                      switch_reg_select, // address decode
  input  wire                      stack_limit_select, // address decode
  input  wire                      scratch_select,    // scratch-pad decode
  input  wire                      bus_write,         // control decode: write
  input  wire [`PBOA_DATA_W-1:0]   reg_read_data,     // selected register data
  input  wire [`PBOA_DATA_W-1:0]   switch_data,       // switch register value
  input  wire [`PBOA_DATA_W-1:0]   bus_data_in,       // bus data lines
  output reg                       owns_bus_flag,     // processor owns bus
  output wire                      cycle_start,       // processor cycle may start
  output reg                       dma_request_flag,  // dma request held
  output reg                       priority_request_flag, // priority request held
  output reg                       console_halt_request_flag, // halt held
  output wire                      service_request,   // branch to service
  output reg                       npg_out,           // non-processor grant
  output reg  [`PBOA_LVL_W-1:0]    bg_out,            // level grants 7..4
  output reg                       ssyn_out,          // slave sync answer
  output reg                       reg_clock,         // register clock pulse
  output reg  [`PBOA_DATA_W-1:0]   bus_data_out,      // read data to bus
  output reg                       bus_data_oe,       // drive bus data
  output reg  [`PBOA_DATA_W-1:0]   internal_data_mux, // write data inward
  output reg                       switch_data_gate,  // switch data enabled
  output wire                      no_ack_timeout_flag, // sack timeout
  output wire                      no_data_timeout_flag, // ssyn timeout
  output wire                      microprogram_forced_jump // trap jump
);
  localparam [3:0] ST_IDLE = `PBOA_ST_IDLE;
  localparam [3:0] ST_GRANT = `PBOA_ST_GRANT;
  localparam [3:0] ST_WAIT_ACK = `PBOA_ST_WAIT_ACK;
  localparam [3:0] ST_LENT = `PBOA_ST_LENT;
  localparam integer DLY_I = `PBOA_CMP_DLY_CYC;
  localparam [`PBOA_DLY_W-1:0] DLY_LAST = DLY_I[`PBOA_DLY_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // every bus pin except the data lines bus_data_in, reg_read_data and switch_data is asynchronous to the processor clock: two cycles late
  wire [`PBOA_LVL_W-1:0] br_s;
  wire msyn_s, ssyn_s, sack_s, npr_s, halt_s, aclo_s, extclk_s;
  wire ps_s, sr_s, sl_s, sp_s, wr_s;
  pboa_sync #(.W(`PBOA_LVL_W + 12)) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .d      ({bus_br, bus_msyn, bus_ssyn_in, bus_sack, bus_npr, console_halt, ac_low,
              external_request_clock, status_reg_select, switch_reg_select,
              stack_limit_select, scratch_select, bus_write}),
    .q      ({br_s, msyn_s, ssyn_s, sack_s, npr_s, halt_s, aclo_s, extclk_s,
              ps_s, sr_s, sl_s, sp_s, wr_s})
  );

  reg msyn_d_r, ext_d_r, proc_cycle_r, read_pause_r, release_r;
  reg [3:0] state_r;
  wire msyn_rise = msyn_s && !msyn_d_r;
  wire ext_rise  = extclk_s && !ext_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // request clocks
  // msyn clocks priority requests only when the processor is not the master; any msyn rise clocks dma requests
  wire msyn_clk  = msyn_rise && !proc_cycle_r;
  wire p_msyn    = msyn_rise && proc_cycle_r;
  wire wait_clk  = service_branch_test || ext_rise;
  wire dma_request_clock = msyn_clk || clock_restart || bus_cycle_begin
                           || service_branch_test || p_msyn
                           || instruction_load_clock || ext_rise;
  wire dma_data  = npr_s && !aclo_s && !console_op && !read_pause_r;
  wire priority_request_clock = msyn_clk || service_branch_test
                                || instruction_load_clock;

  ////////////////////////////////////////////////////////////////////////////
  // priority comparison and one-shot delay
  wire [`PBOA_LVL_W-1:0] above;
  reg  [`PBOA_LVL_W-1:0] top_lvl;
  wire request_above_priority = |above;
  genvar g;
  generate
    for (g = 0; g < `PBOA_LVL_W; g = g + 1) begin : g_cmp
      // level number of this request line, lowest line is the base level
      localparam integer LVL_I = `PBOA_PRI_BASE + g;
      localparam [`PBOA_PRI_W-1:0] LVL = LVL_I[`PBOA_PRI_W-1:0];
      assign above[g] = br_s[g] && (LVL > status_priority);
    end
  endgenerate
  integer i;
  always @* begin
    top_lvl = {`PBOA_LVL_W{1'b0}};
    for (i = 0; i < `PBOA_LVL_W; i = i + 1)
      if (above[i])
        top_lvl = {`PBOA_LVL_W{1'b0}} | ({{(`PBOA_LVL_W-1){1'b0}}, 1'b1} << i);
  end

  reg [`PBOA_DLY_W-1:0] delay_r;
  reg                   delay_run_r;
  wire priority_compare_delay = delay_run_r && (delay_r == DLY_LAST);

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      delay_r     <= {`PBOA_DLY_W{1'b0}};
      delay_run_r <= 1'b0;
    end else if (priority_request_clock) begin
      delay_r     <= {`PBOA_DLY_W{1'b0}};
      delay_run_r <= 1'b1;
    end else if (priority_compare_delay) begin
      delay_run_r <= 1'b0;
    end else if (delay_run_r) begin
      delay_r <= delay_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags, ownership, read-pause
  wire grant_npr = dma_request_flag && state_r == ST_IDLE && !proc_cycle_r;
  wire issue_level_grant  = end_of_instruction && priority_request_flag && state_r == ST_IDLE
                   && !proc_cycle_r && !dma_request_flag;
  wire regained  = (state_r == ST_WAIT_ACK && no_ack_timeout_flag)
                   || (state_r == ST_LENT && !msyn_s && !sack_s);
  // a request caught by this very strobe wins over the processor cycle;
  // the processor must strobe again once the dma transfer is over
  assign cycle_start = bus_cycle_begin && owns_bus_flag && !ssyn_s
                       && !release_r && !dma_request_flag
                       && !dma_data;
  assign service_request = priority_request_flag
                           || console_halt_request_flag;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      msyn_d_r   <= 1'b0;
      ext_d_r    <= 1'b0;
      dma_request_flag <= 1'b0;
      priority_request_flag <= 1'b0;
      console_halt_request_flag <= 1'b0;
      owns_bus_flag <= 1'b1;
      proc_cycle_r <= 1'b0;
      read_pause_r <= 1'b0;
      release_r  <= 1'b0;
    end else begin
      msyn_d_r <= msyn_s;
      ext_d_r  <= extclk_s;
      if (dma_request_clock)
        dma_request_flag <= dma_data;
      else if (grant_npr)
        dma_request_flag <= 1'b0;
      if (priority_compare_delay) begin
        priority_request_flag <= request_above_priority;
        console_halt_request_flag <= halt_s;
      end else if (issue_level_grant) begin
        priority_request_flag <= 1'b0;
      end
      if (cycle_start)
        proc_cycle_r <= 1'b1;
      else if (cycle_end)
        proc_cycle_r <= 1'b0;
      // paired dato closes the read-pause window
      if (cycle_start && cycle_is_datip)
        read_pause_r <= 1'b1;
      else if (cycle_start && cycle_is_dato)
        read_pause_r <= 1'b0;
      // ownership: dma load and wait clocks drop it, regaining restores it
      if ((dma_request_clock && dma_data) || wait_clk)
        owns_bus_flag <= 1'b0;
      else if (regained || (state_r == ST_IDLE && !dma_request_flag))
        owns_bus_flag <= 1'b1;
      else if (cycle_start || cycle_end)
        owns_bus_flag <= owns_bus_flag;
      release_r <= (state_r != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // grant state machine
  reg [3:0] state_nxt;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:     if (grant_npr || issue_level_grant) state_nxt = ST_GRANT;
      ST_GRANT:    state_nxt = ST_WAIT_ACK;
      ST_WAIT_ACK: if (sack_s) state_nxt = ST_LENT;
                   else if (no_ack_timeout_flag) state_nxt = ST_IDLE;
      ST_LENT:     if (regained) state_nxt = ST_IDLE;
      default:     state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      npg_out <= 1'b0;
      bg_out  <= {`PBOA_LVL_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && grant_npr)
        npg_out <= 1'b1;
      else if (state_r == ST_IDLE && issue_level_grant)
        bg_out <= top_lvl;
      else if (sack_s || state_nxt == ST_IDLE) begin
        npg_out <= 1'b0;
        bg_out  <= {`PBOA_LVL_W{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeouts
  // the no-ack count only runs while a grant waits for its sack
  pboa_timeout #(.TMO_CYC(TMO_CYC)) u_no_ack_timeout_flag (
    .clock     (clock),
    .arst_n    (arst_n),
    .run       (state_r == ST_WAIT_ACK && !sack_s),
    .disable_t (no_ack_timeout_flag_disable),
    .clear     (state_r == ST_IDLE),
    .expired   (no_ack_timeout_flag)
  );
  pboa_timeout #(.TMO_CYC(TMO_CYC)) u_no_data_timeout_flag (
    .clock     (clock),
    .arst_n    (arst_n),
    .run       (proc_cycle_r && !ssyn_s),
    .disable_t (no_data_timeout_flag_disable),
    .clear     (no_data_timeout_flag_ack),
    .expired   (no_data_timeout_flag)
  );
  assign microprogram_forced_jump = no_data_timeout_flag;

  ////////////////////////////////////////////////////////////////////////////
  // register answer on bus references
  wire hit_reg = msyn_s && (ps_s || sr_s || (sl_s && stack_limit_fitted))
                 && !sp_s;
  wire gate_sw = sr_s && !remote_begin;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ssyn_out          <= 1'b0;
      reg_clock         <= 1'b0;
      bus_data_out      <= {`PBOA_DATA_W{1'b0}};
      bus_data_oe       <= 1'b0;
      internal_data_mux <= {`PBOA_DATA_W{1'b0}};
      switch_data_gate  <= 1'b0;
    end else begin
      ssyn_out         <= hit_reg;
      reg_clock        <= hit_reg && !ssyn_out && wr_s;
      switch_data_gate <= gate_sw;
      bus_data_oe      <= hit_reg && !wr_s && !(sr_s && remote_begin);
      if (hit_reg && !wr_s)
        bus_data_out <= gate_sw ? switch_data : reg_read_data;
      if (hit_reg && wr_s)
        internal_data_mux <= bus_data_in;
    end
  end
endmodule // pboa_arbiter
`default_nettype wire

// ---- verification/pboa_asserts.sv ----
// port checker for the bus ownership arbiter
`timescale 1ns/10ps
`default_nettype none
module pboa_asserts #(
  parameter TMO_CYC = 3000
) (
  input wire logic       clock,                   // clock
  input wire logic       arst_n,                  // reset
  input wire logic       owns_bus_flag,           // owner
  input wire logic       cycle_start,             // own cycle
  input wire logic       npg_out,                 // dma grant
  input wire logic [3:0] bg_out,                  // level grants
  input wire logic       dma_request_flag,        // dma held
  input wire logic       ssyn_out,                // answer
  input wire logic       status_reg_select,       // decode
  input wire logic       switch_reg_select,       // decode
  input wire logic       stack_limit_select,      // decode
  input wire logic       stack_limit_fitted,      // option
  input wire logic       console_op,              // console
  input wire logic       ac_low,                  // power low
  input wire logic       no_ack_timeout_flag_disable,          // maint
  input wire logic       no_data_timeout_flag_disable,           // maint
  input wire logic       no_ack_timeout_flag,     // sack tmo
  input wire logic       no_data_timeout_flag,    // ssyn tmo
  input wire logic       microprogram_forced_jump // trap
);
  logic [15:0] gnt_cnt_r;
  wire         sel_ok = status_reg_select | switch_reg_select
                        | (stack_limit_select & stack_limit_fitted);
  // run of grant cycles, so a sack timeout cannot fire early
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) gnt_cnt_r <= 16'h0000;
    else if (npg_out | (|bg_out)) gnt_cnt_r <= gnt_cnt_r + 16'h0001;
    else gnt_cnt_r <= 16'h0000;
  end
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_one_grant; $onehot0({npg_out, bg_out}); endproperty
  a_one_grant: assert property (p_one_grant) else $error("several grants at once");
  property p_grant_unowned; npg_out |-> !owns_bus_flag; endproperty
  a_grant_unowned: assert property (p_grant_unowned) else $error("grant while owning");
  property p_start_gate; cycle_start |-> owns_bus_flag && !npg_out; endproperty
  a_start_gate: assert property (p_start_gate) else $error("cycle without bus");
  property p_ssyn_src; ssyn_out |-> $past(sel_ok, 2) || $past(sel_ok, 3); endproperty
  a_ssyn_src: assert property (p_ssyn_src) else $error("answer without select");
  property p_inhibit;
    ($past(console_op) || ($past(ac_low, 2) && $past(ac_low, 3))) |-> !$rose(dma_request_flag);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("dma loaded while held off");
  property p_jump; microprogram_forced_jump == no_data_timeout_flag; endproperty
  a_jump: assert property (p_jump) else $error("jump not tied to no-data");
  property p_tmo_off;
    (no_ack_timeout_flag_disable && $past(no_ack_timeout_flag_disable) |-> !$rose(no_ack_timeout_flag)) and
    (no_data_timeout_flag_disable && $past(no_data_timeout_flag_disable) |-> !$rose(no_data_timeout_flag));
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("disabled timeout fired");
  property p_sack_wait; $rose(no_ack_timeout_flag) |-> $past(gnt_cnt_r) >= TMO_CYC - 3; endproperty
  a_sack_wait: assert property (p_sack_wait) else $error("sack timeout early");
  cover property ($rose(npg_out));
  cover property ($rose(no_ack_timeout_flag));
  cover property (ssyn_out && stack_limit_select);
endmodule // pboa_asserts
bind pboa_arbiter pboa_asserts #(.TMO_CYC(TMO_CYC)) i_chk (.*);
`default_nettype wire

// ---- verification/pboa_periph.sv ----
// far-side requester: raises requests, answers grants, runs a short master cycle
`timescale 1ns/10ps
`default_nettype none
module pboa_periph (
  input  wire logic       clock,    // clock
  input  wire logic       arst_n,   // reset
  input  wire logic       want_npr, // raise dma request
  input  wire logic [3:0] want_br,  // raise level requests
  input  wire logic [3:0] ack_dly,  // cycles to sack, 0 never
  input  wire logic       tb_msyn,  // bench master sync
  input  wire logic       npg_out,  // dma grant
  input  wire logic [3:0] bg_out,   // level grants
  output logic            bus_npr,  // dma request
  output logic      [3:0] bus_br,   // level requests
  output logic            bus_sack, // selection ack
  output wire logic       bus_msyn  // master sync
);
  logic [1:0] st_r;
  logic [3:0] cnt_r;
  logic       msyn_r;
  assign bus_msyn = msyn_r | tb_msyn;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {st_r, cnt_r, msyn_r, bus_npr, bus_br, bus_sack} <= '0;
    end else begin
      bus_npr <= bus_npr | want_npr;
      bus_br <= bus_br | want_br;
      case (st_r)
        2'h0: if ((npg_out & bus_npr) | (|(bg_out & bus_br))) begin
          st_r <= 2'h1;
          cnt_r <= ack_dly;
        end
        // grant withdrawn before we answered: give the request up
        2'h1: if (!npg_out && bg_out == 4'h0) begin
          st_r <= 2'h0;
          {bus_npr, bus_br} <= 5'h00;
        end else if (cnt_r == 4'h1) begin
          bus_sack <= 1'b1;
          {bus_npr, bus_br} <= 5'h00;
          st_r <= 2'h2;
          cnt_r <= 4'h4;
        end else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        2'h2: begin
          msyn_r <= (cnt_r != 4'h0);
          cnt_r <= cnt_r - 4'h1;
          if (cnt_r == 4'h0) st_r <= 2'h3;
        end
        default: begin
          bus_sack <= 1'b0;
          st_r <= 2'h0;
        end
      endcase
    end
  end
endmodule // pboa_periph
`default_nettype wire

// ---- verification/pboa_arbiter_tb.sv ----
// self-checking bench for the bus ownership arbiter
`timescale 1ns/10ps
`default_nettype none
module pboa_arbiter_tb;
  localparam TMO = 10; // short stand-in for the 15 us count
  logic clock = 1'b0;
  logic arst_n, bus_cycle_begin, cycle_end, clock_restart, service_branch_test;
  logic instruction_load_clock, cycle_is_datip, cycle_is_dato, console_op, remote_begin;
  logic stack_limit_fitted, end_of_instruction, no_ack_timeout_flag_disable, no_data_timeout_flag_disable, no_data_timeout_flag_ack;
  logic bus_msyn, bus_ssyn_in, bus_sack, bus_npr, console_halt, ac_low, external_request_clock;
  logic status_reg_select, switch_reg_select, stack_limit_select, scratch_select, bus_write;
  logic owns_bus_flag, cycle_start, dma_request_flag, priority_request_flag, npg_out;
  logic console_halt_request_flag, service_request, ssyn_out, reg_clock, bus_data_oe;
  logic switch_data_gate, no_ack_timeout_flag, no_data_timeout_flag, microprogram_forced_jump;
  logic want_npr, tb_msyn, rc_seen, nack_seen;
  logic [2:0]  status_priority;
  logic [3:0]  bus_br, bg_out, want_br, ack_dly;
  logic [15:0] reg_read_data, switch_data, bus_data_in, bus_data_out, internal_data_mux;
  int          err_count = 0;
  int          check_count = 0;
  pboa_arbiter #(.TMO_CYC(TMO)) i_dut (.*);
  pboa_periph i_far (.clock(clock), .arst_n(arst_n), .want_npr(want_npr), .want_br(want_br),
    .ack_dly(ack_dly), .tb_msyn(tb_msyn), .npg_out(npg_out), .bg_out(bg_out),
    .bus_npr(bus_npr), .bus_br(bus_br), .bus_sack(bus_sack), .bus_msyn(bus_msyn));
  always #2.5 clock = ~clock;
  // one-cycle pulses would slip past a check made later
  always @(posedge clock) begin
    if (reg_clock === 1'b1) rc_seen = 1'b1;
    if (no_ack_timeout_flag === 1'b1) nack_seen = 1'b1;
  end
  //////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic dma(input int src, input int inh, input logic [3:0] dly);
    ack_dly = dly;
    nack_seen = 1'b0;
    pulse(want_npr);
    tick(3);
    console_op = (inh == 1);
    ac_low = (inh == 2);
    if (inh != 0) begin
      tick(3);
      pulse(service_branch_test);
      tick(4);
      chk("dma held", 16'h0000, dma_request_flag);
      console_op = 1'b0;
      ac_low = 1'b0;
      tick(3);
    end
    if (inh == 3) begin
      cycle_is_dato = 1'b1;
      pulse(bus_cycle_begin);
      cycle_is_dato = 1'b0;
      pulse(cycle_end);
    end
    case (src)
      0: pulse(bus_cycle_begin);
      1: pulse(service_branch_test);
      2: pulse(external_request_clock);
      3: pulse(clock_restart);
      default: pulse(instruction_load_clock);
    endcase
    for (int i = 0; i < 20 && npg_out !== 1'b1; i++) tick(1);
    chk("npg", 16'h0001, npg_out);
    chk("owns off", 16'h0000, owns_bus_flag);
    for (int i = 0; i < 100 && owns_bus_flag !== 1'b1; i++) tick(1);
    chk("owns back", 16'h0001, owns_bus_flag);
    chk("no ack flag", dly == 4'h0 && !no_ack_timeout_flag_disable, nack_seen);
    pulse(cycle_end);
    pulse(no_data_timeout_flag_ack);
  endtask
  task automatic prio(input int lvl, input logic [2:0] pri, input logic exp);
    status_priority = pri;
    ack_dly = 4'h2;
    want_br = 4'h1 << lvl;
    tick(1);
    want_br = 4'h0;
    tick(3);
    pulse(instruction_load_clock);
    tick(14);
    chk("prio flag", exp, priority_request_flag);
    chk("prio service", exp, service_request);
    if (exp) begin
      pulse(end_of_instruction);
      for (int i = 0; i < 20 && bg_out === 4'h0; i++) tick(1);
      chk("grant level", 4'h1 << lvl, bg_out);
      tick(20);
    end
  endtask
  task automatic bref(input int sel, input logic wr, input logic rem, input logic exp);
    {scratch_select, stack_limit_select, switch_reg_select, status_reg_select} = 4'h1 << sel;
    {bus_write, remote_begin, tb_msyn, rc_seen} = {wr, rem, 2'b10};
    tick(5);
    chk("ssyn", exp, ssyn_out);
    chk("data drive", exp & !wr & !(sel == 1 && rem), bus_data_oe);
    if (exp && wr) chk("write mux", bus_data_in, internal_data_mux);
    if (exp && wr) chk("reg clock", 16'h0001, rc_seen);
    if (sel == 0 && !wr) chk("read data", reg_read_data, bus_data_out);
    if (sel == 1 && !wr && !rem) chk("switch data", switch_data, bus_data_out);
    if (sel == 1) chk("switch gate", !rem, switch_data_gate);
    {scratch_select, stack_limit_select, switch_reg_select, status_reg_select} = 4'h0;
    {bus_write, remote_begin, tb_msyn} = 3'h0;
    tick(4);
    chk("ssyn off", 16'h0000, ssyn_out);
  endtask
  initial begin
    {arst_n, bus_cycle_begin, cycle_end, clock_restart, service_branch_test} = '0;
    {instruction_load_clock, cycle_is_datip, cycle_is_dato, console_op, remote_begin} = '0;
    {stack_limit_fitted, end_of_instruction, no_ack_timeout_flag_disable, no_data_timeout_flag_disable, no_data_timeout_flag_ack} = '0;
    {bus_ssyn_in, console_halt, ac_low, external_request_clock, bus_write, tb_msyn} = '0;
    {status_reg_select, switch_reg_select, stack_limit_select, scratch_select} = '0;
    {want_npr, want_br, ack_dly, status_priority, rc_seen, nack_seen} = '0;
    {reg_read_data, switch_data, bus_data_in} = {16'h5A3C, 16'h1234, 16'hC0DE};
    tick(3);
    arst_n = 1'b1;
    tick(3);
    chk("owns reset", 16'h0001, owns_bus_flag);
    chk("grants reset", 16'h0000, {npg_out, bg_out});
    for (int d = 0; d < 2; d++) begin
      no_data_timeout_flag_disable = d[0];
      pulse(bus_cycle_begin);
      tick(30);
      chk("no_data_timeout_flag", !d[0], no_data_timeout_flag);
      chk("jump", !d[0], microprogram_forced_jump);
      pulse(cycle_end);
      pulse(no_data_timeout_flag_ack);
      chk("no_data_timeout_flag clear", 16'h0000, no_data_timeout_flag);
    end
    no_data_timeout_flag_disable = 1'b0;
    bref(0, 1'b0, 1'b0, 1'b1);
    bref(0, 1'b1, 1'b0, 1'b1);
    bref(1, 1'b0, 1'b0, 1'b1);
    bref(1, 1'b0, 1'b1, 1'b1);
    stack_limit_fitted = 1'b1;
    bref(2, 1'b0, 1'b0, 1'b1);
    stack_limit_fitted = 1'b0;
    bref(2, 1'b0, 1'b0, 1'b0);
    bref(3, 1'b0, 1'b0, 1'b0);
    for (int h = 1; h >= 0; h--) begin
      console_halt = h[0];
      tick(3);
      pulse(service_branch_test);
      tick(14);
      chk("halt flag", h, console_halt_request_flag);
      chk("halt service", h, service_request);
    end
    for (int l = 0; l < 4; l++) prio(l, 3'h3, 1'b1);
    prio(0, 3'h4, 1'b0);
    prio(3, 3'h7, 1'b0);
    prio(3, 3'h6, 1'b1);
    dma(0, 0, 4'h1);
    dma(1, 1, 4'h2);
    dma(2, 2, 4'h3);
    cycle_is_datip = 1'b1;
    pulse(bus_cycle_begin);
    cycle_is_datip = 1'b0;
    pulse(cycle_end);
    dma(0, 3, 4'h2);
    dma(3, 0, 4'h4);
    dma(4, 0, 4'h1);
    dma(1, 0, 4'h0);
    no_ack_timeout_flag_disable = 1'b1;
    dma(1, 0, 4'hF);
    end_sim;
  end
  initial begin
    repeat (8000) @(posedge clock);
    err_count++;
    $display("mismatch watchdog expected done seen hang");
    end_sim;
  end
endmodule // pboa_arbiter_tb
`default_nettype wire
